/* verilog/bors_map.svh */
`ifndef BORS_MAP_SVH
`define BORS_MAP_SVH

// register byte offsets
`define BORS_OFF_CTRL 8'h00
`define BORS_OFF_CFG 8'h04
`define BORS_OFF_STAT 8'h08

// brownout_control fields
`define BORS_CTRL_SWEN 7
`define BORS_CTRL_FAST 6
`define BORS_CTRL_RDY 0
`define BORS_CTRL_SWEN_RST 1'b1
`define BORS_CTRL_FAST_RST 1'b0

// configuration register fields
`define BORS_CFG_MODE_LO 0
`define BORS_CFG_MODE_HI 1
`define BORS_CFG_POWERUP_DELAY_ENABLE_N_N 2
`define BORS_CFG_LPEN 3
`define BORS_CFG_LEVEL 4
`define BORS_CFG_PINEN 5
`define BORS_CFG_STKEN 6
`define BORS_CFG_MODE_RST 2'h3
`define BORS_CFG_POWERUP_DELAY_ENABLE_N_N_RST 1'b1
`define BORS_CFG_LPEN_RST 1'b0
`define BORS_CFG_LEVEL_RST 1'b0
`define BORS_CFG_PINEN_RST 1'b1
`define BORS_CFG_STKEN_RST 1'b1

// status register fields
`define BORS_STAT_BOR 0
`define BORS_STAT_POR 1
`define BORS_STAT_RUN 2
`define BORS_STAT_TIMER 3
`define BORS_STAT_WAKE 4
`define BORS_STAT_SLEEP 5

// brown-out mode codes
`define BORS_MODE_OFF 2'h0
`define BORS_MODE_SW 2'h1
`define BORS_MODE_NOSLEEP 2'h2
`define BORS_MODE_ON 2'h3

// timing
`define BORS_CLK_PERIOD_NS 5
`define BORS_POWERUP_DELAY_TIMER_TIME_MS 64
`define BORS_FILTER_TIME_NS 1000
`define BORS_FILTER_CYC ((`BORS_FILTER_TIME_NS + `BORS_CLK_PERIOD_NS - 1) / `BORS_CLK_PERIOD_NS)
`define BORS_POWERUP_DELAY_TIMER_CYC ((`BORS_POWERUP_DELAY_TIMER_TIME_MS * 1000000) / `BORS_CLK_PERIOD_NS)

`endif

/* verilog/bors_pkg.sv */
package bors_pkg;

`include "bors_map.svh"

  typedef enum logic [1:0] {
    BORS_MODE_OFF_E = `BORS_MODE_OFF,
    BORS_MODE_SW_E = `BORS_MODE_SW,
    BORS_MODE_NOSLEEP_E = `BORS_MODE_NOSLEEP,
    BORS_MODE_ON_E = `BORS_MODE_ON
  } bors_mode_e;

  typedef enum logic [2:0] {
    BORS_ST_HOLD,
    BORS_ST_TIMER,
    BORS_ST_START,
    BORS_ST_RUN,
    BORS_ST_SLEEP,
    BORS_ST_WAKE
  } bors_state_e;

  typedef logic [7:0] bors_addr_t;
  typedef logic [31:0] bors_data_t;

endpackage

/* verilog/bors_sync.sv */
`timescale 1ns/1ps
module bors_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // data
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);

  logic [W-1:0] stage1_r;

  // two flops per bit; the first stage feeds only the second
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          stage1_r[i] <= 1'b0;
          dout[i] <= 1'b0;
        end else begin
          stage1_r[i] <= din[i];
          dout[i] <= stage1_r[i];
        end
      end
    end
  endgenerate

endmodule

/* verilog/bors_delay_timer.sv */
`timescale 1ns/1ps
module bors_delay_timer #(
  parameter int unsigned CYCLES = 12800000
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // control
  input wire logic hold,
  // status
  output logic running,
  output logic done
);

  logic [23:0] cnt_r;

  // cleared while held, counts once released, stops at the end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 24'h000000;
    end else if (hold) begin
      cnt_r <= 24'h000000;
    end else if (!done) begin
      cnt_r <= cnt_r + 24'h000001;
    end
  end

  assign done = (cnt_r == CYCLES[23:0]);
  assign running = !hold && !done;

endmodule

/* verilog/bors_sequencer.sv */
// Decided for this implementation: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`include "bors_map.svh"
module bors_sequencer
  import bors_pkg::*;
#(
  parameter int unsigned POWERUP_DELAY_TIMER_CYCLES = `BORS_POWERUP_DELAY_TIMER_CYC
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire bors_pkg::bors_addr_t paddr,
  input wire bors_pkg::bors_data_t pwdata,
  output bors_pkg::bors_data_t prdata,
  output logic pready,
  output logic pslverr,
  // analog supply detectors
  input wire logic supply_por_low,
  input wire logic undervoltage,
  input wire logic brownout_circuit_ready,
  input wire logic lowpower_supply_low,
  // reset sources
  input wire logic external_reset_pin_n,
  input wire logic watchdog_timer_reset,
  input wire logic reset_instruction,
  input wire logic stack_overflow,
  input wire logic stack_underflow,
  input wire logic prog_mode_exit,
  input wire logic osc_startup_done,
  // core side
  input wire logic core_sleep,
  output logic core_reset_n,
  output logic wake_stall,
  // analog and power control
  output logic brownout_enable,
  output logic bandgap_force_on,
  output logic brownout_level_sel,
  output logic brownout_generic,
  output logic powerup_delay_running
);

  import bors_pkg::*;

  localparam int unsigned FILTER_CYC = `BORS_FILTER_CYC;

  // decoded register index
  typedef enum logic [1:0] {
    BORS_REG_CTRL,
    BORS_REG_CFG,
    BORS_REG_STAT,
    BORS_REG_NONE
  } bors_reg_e;

  function automatic bors_reg_e reg_decode(input bors_addr_t addr);
    bors_reg_e r;
    r = BORS_REG_NONE;
    if (addr == `BORS_OFF_CTRL) begin
      r = BORS_REG_CTRL;
    end else if (addr == `BORS_OFF_CFG) begin
      r = BORS_REG_CFG;
    end else if (addr == `BORS_OFF_STAT) begin
      r = BORS_REG_STAT;
    end
    return r;
  endfunction

  bors_state_e state_r;
  bors_state_e state_nxt;
  bors_mode_e mode_r;
  logic sw_enable_r;
  logic fast_start_r;
  logic powerup_delay_timer_enable_n_r;
  logic lp_enable_r;
  logic level_sel_r;
  logic pin_enable_r;
  logic stack_enable_r;
  logic bor_flag_r;
  logic por_flag_r;
  logic [15:0] filter_cnt_r;
  logic main_bor_r;
  logic generic_r;
  logic [31:0] rdata_r;
  logic err_r;

  logic [4:0] async_in;
  logic [4:0] async_s;
  logic por_s;
  logic uv_s;
  logic rdy_s;
  logic lp_s;
  logic prog_s;
  logic osc_s;

  logic setup_phase;
  logic wr_access;
  bors_reg_e sel_reg;
  logic supervise_on;
  logic protect_on;
  logic wait_mode;
  logic start_ok;
  logic lp_req;
  logic generic_nxt;
  logic restart;
  logic timer_hold;
  logic timer_done;
  logic seq_release;
  logic async_req;
  logic release_arst_n;

  // detector and programming-exit inputs cross into the clock domain
  assign async_in = {prog_mode_exit, lowpower_supply_low, brownout_circuit_ready, undervoltage,
                     supply_por_low};

  bors_sync #(
    .W(5)
  ) u_in_sync (
    .clk(pclk),
    .arst_n(presetn),
    .din(async_in),
    .dout(async_s)
  );

  bors_sync #(
    .W(1)
  ) u_osc_sync (
    .clk(pclk),
    .arst_n(presetn),
    .din(osc_startup_done),
    .dout(osc_s)
  );

  assign por_s = async_s[0];
  assign uv_s = async_s[1];
  assign rdy_s = async_s[2];
  assign lp_s = async_s[3];
  assign prog_s = async_s[4];

  // supervision and protection per mode
  always_comb begin
    unique case (mode_r)
      BORS_MODE_ON_E: supervise_on = 1'b1;
      BORS_MODE_NOSLEEP_E: supervise_on = (state_r != BORS_ST_SLEEP);
      BORS_MODE_SW_E: supervise_on = sw_enable_r;
      BORS_MODE_OFF_E: supervise_on = 1'b0;
    endcase
  end

  assign protect_on = supervise_on && rdy_s;
  assign wait_mode = (mode_r == BORS_MODE_ON_E) || (mode_r == BORS_MODE_NOSLEEP_E);
  assign start_ok = osc_s && (!wait_mode || (rdy_s && !uv_s));

  // undervoltage filter: short dips never reach the reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      filter_cnt_r <= 16'h0000;
      main_bor_r <= 1'b0;
    end else if (protect_on && uv_s) begin
      if (filter_cnt_r != FILTER_CYC[15:0]) begin
        filter_cnt_r <= filter_cnt_r + 16'h0001;
      end
      main_bor_r <= (filter_cnt_r == FILTER_CYC[15:0]);
    end else begin
      filter_cnt_r <= 16'h0000;
      main_bor_r <= 1'b0;
    end
  end

  assign lp_req = lp_enable_r && lp_s;
  assign generic_nxt = main_bor_r || lp_req;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      generic_r <= 1'b0;
    end else begin
      generic_r <= generic_nxt;
    end
  end

  // power-on, programming exit or brown-out restart the whole start-up
  assign restart = por_s || prog_s || generic_r;

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      BORS_ST_HOLD: begin
        if (!restart) begin
          state_nxt = powerup_delay_timer_enable_n_r ? BORS_ST_START : BORS_ST_TIMER;
        end
      end
      BORS_ST_TIMER: begin
        if (timer_done) begin
          state_nxt = BORS_ST_START;
        end
      end
      BORS_ST_START: begin
        if (start_ok) begin
          state_nxt = BORS_ST_RUN;
        end
      end
      BORS_ST_RUN: begin
        if (core_sleep) begin
          state_nxt = BORS_ST_SLEEP;
        end
      end
      BORS_ST_SLEEP: begin
        if (!core_sleep) begin
          // only off-in-sleep mode delays wake-up
          state_nxt = (mode_r == BORS_MODE_NOSLEEP_E) ? BORS_ST_WAKE : BORS_ST_RUN;
        end
      end
      BORS_ST_WAKE: begin
        if (rdy_s) begin
          state_nxt = BORS_ST_RUN;
        end
      end
    endcase
    if (restart) begin
      state_nxt = BORS_ST_HOLD;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= BORS_ST_HOLD;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign timer_hold = (state_r != BORS_ST_TIMER);

  bors_delay_timer #(
    .CYCLES(POWERUP_DELAY_TIMER_CYCLES)
  ) u_powerup_delay_timer (
    .clk(pclk),
    .rst_n(presetn),
    .hold(timer_hold),
    .running(powerup_delay_running),
    .done(timer_done)
  );

  // core reset: source, power-on and programming-exit requests assert at once; brown-out and release are synchronised
  assign seq_release = (state_r == BORS_ST_RUN) || (state_r == BORS_ST_SLEEP) ||
                       (state_r == BORS_ST_WAKE);
  assign async_req = supply_por_low || prog_mode_exit ||
                     (pin_enable_r && !external_reset_pin_n) || watchdog_timer_reset ||
                     reset_instruction ||
                     (stack_enable_r && (stack_overflow || stack_underflow));
  assign release_arst_n = presetn && !async_req;

  bors_sync #(
    .W(1)
  ) u_rel_sync (
    .clk(pclk),
    .arst_n(release_arst_n),
    .din(seq_release),
    .dout(core_reset_n)
  );

  // apb access
  assign setup_phase = psel && !penable;
  assign wr_access = psel && penable && pwrite;
  assign sel_reg = reg_decode(paddr);
  assign pready = psel && penable;
  assign pslverr = err_r && psel && penable;

  // control register: power-on or brown-out restores it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_enable_r <= `BORS_CTRL_SWEN_RST;
      fast_start_r <= `BORS_CTRL_FAST_RST;
    end else if (por_s || generic_r) begin
      sw_enable_r <= `BORS_CTRL_SWEN_RST;
      fast_start_r <= `BORS_CTRL_FAST_RST;
    end else if (wr_access && sel_reg == BORS_REG_CTRL) begin
      sw_enable_r <= pwdata[`BORS_CTRL_SWEN];
      fast_start_r <= pwdata[`BORS_CTRL_FAST];
    end
  end

  // configuration register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_r <= bors_mode_e'(`BORS_CFG_MODE_RST);
      powerup_delay_timer_enable_n_r <= `BORS_CFG_POWERUP_DELAY_ENABLE_N_N_RST;
      lp_enable_r <= `BORS_CFG_LPEN_RST;
      level_sel_r <= `BORS_CFG_LEVEL_RST;
      pin_enable_r <= `BORS_CFG_PINEN_RST;
      stack_enable_r <= `BORS_CFG_STKEN_RST;
    end else if (wr_access && sel_reg == BORS_REG_CFG) begin
      mode_r <= bors_mode_e'(pwdata[`BORS_CFG_MODE_HI:`BORS_CFG_MODE_LO]);
      powerup_delay_timer_enable_n_r <= pwdata[`BORS_CFG_POWERUP_DELAY_ENABLE_N_N];
      lp_enable_r <= pwdata[`BORS_CFG_LPEN];
      level_sel_r <= pwdata[`BORS_CFG_LEVEL];
      pin_enable_r <= pwdata[`BORS_CFG_PINEN];
      stack_enable_r <= pwdata[`BORS_CFG_STKEN];
    end
  end

  // sticky cause flags, write one to clear; a new event wins over the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bor_flag_r <= 1'b0;
      por_flag_r <= 1'b1;
    end else begin
      if (generic_r) begin
        bor_flag_r <= 1'b1;
      end else if (wr_access && sel_reg == BORS_REG_STAT && pwdata[`BORS_STAT_BOR]) begin
        bor_flag_r <= 1'b0;
      end
      if (por_s || prog_s) begin
        por_flag_r <= 1'b1;
      end else if (wr_access && sel_reg == BORS_REG_STAT && pwdata[`BORS_STAT_POR]) begin
        por_flag_r <= 1'b0;
      end
    end
  end

  // read data and error captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_r <= 32'h00000000;
      err_r <= 1'b0;
    end else if (setup_phase) begin
      rdata_r <= 32'h00000000;
      err_r <= (sel_reg == BORS_REG_NONE);
      unique case (sel_reg)
        BORS_REG_CTRL: begin
          rdata_r[`BORS_CTRL_SWEN] <= sw_enable_r;
          rdata_r[`BORS_CTRL_FAST] <= fast_start_r;
          rdata_r[`BORS_CTRL_RDY] <= rdy_s;
        end
        BORS_REG_CFG: begin
          rdata_r[`BORS_CFG_MODE_HI:`BORS_CFG_MODE_LO] <= mode_r;
          rdata_r[`BORS_CFG_POWERUP_DELAY_ENABLE_N_N] <= powerup_delay_timer_enable_n_r;
          rdata_r[`BORS_CFG_LPEN] <= lp_enable_r;
          rdata_r[`BORS_CFG_LEVEL] <= level_sel_r;
          rdata_r[`BORS_CFG_PINEN] <= pin_enable_r;
          rdata_r[`BORS_CFG_STKEN] <= stack_enable_r;
        end
        BORS_REG_STAT: begin
          rdata_r[`BORS_STAT_BOR] <= bor_flag_r;
          rdata_r[`BORS_STAT_POR] <= por_flag_r;
          rdata_r[`BORS_STAT_RUN] <= (state_r == BORS_ST_RUN);
          rdata_r[`BORS_STAT_TIMER] <= (state_r == BORS_ST_TIMER);
          rdata_r[`BORS_STAT_WAKE] <= (state_r == BORS_ST_WAKE);
          rdata_r[`BORS_STAT_SLEEP] <= (state_r == BORS_ST_SLEEP);
        end
        BORS_REG_NONE: begin
          rdata_r <= 32'h00000000;
        end
      endcase
    end
  end

  assign prdata = rdata_r;

  // outputs to the analog side and the core
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      brownout_enable <= 1'b1;
      bandgap_force_on <= 1'b0;
      brownout_level_sel <= 1'b0;
      brownout_generic <= 1'b0;
      wake_stall <= 1'b0;
    end else begin
      // waiting modes keep the circuit forced on through start and wake
      brownout_enable <= supervise_on || (wait_mode && state_nxt != BORS_ST_SLEEP);
      bandgap_force_on <= fast_start_r &&
                          (mode_r == BORS_MODE_NOSLEEP_E || mode_r == BORS_MODE_SW_E);
      brownout_level_sel <= level_sel_r;
      brownout_generic <= generic_nxt;
      wake_stall <= (state_nxt == BORS_ST_WAKE);
    end
  end

endmodule

/* tb/bors_props.sv */
`timescale 1ns/1ps
module bors_props
  import bors_pkg::*;
#(
  parameter int unsigned POWERUP_DELAY_TIMER_CYCLES = 50
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire bors_pkg::bors_data_t prdata,
  input wire logic pready,
  input wire logic pslverr,
  // supplies and sources
  input wire logic supply_por_low,
  input wire logic undervoltage,
  input wire logic lowpower_supply_low,
  input wire logic watchdog_timer_reset,
  input wire logic reset_instruction,
  input wire logic prog_mode_exit,
  // outputs
  input wire logic core_reset_n,
  input wire logic brownout_generic,
  input wire logic powerup_delay_running
);
  localparam int FILT_CYC = 200;
  logic [8:0] uv_cnt_r;
  logic [7:0] lp_hist_r;
  logic [31:0] run_cnt_r;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // consecutive undervoltage cycles, saturating
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) uv_cnt_r <= 9'h000;
    else if (!undervoltage) uv_cnt_r <= 9'h000;
    else if (uv_cnt_r != 9'h1FF) uv_cnt_r <= uv_cnt_r + 9'h001;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) lp_hist_r <= 8'h00;
    else lp_hist_r <= {lp_hist_r[6:0], lowpower_supply_low};
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) run_cnt_r <= 32'h0;
    else if (powerup_delay_running) run_cnt_r <= run_cnt_r + 32'h1;
    else run_cnt_r <= 32'h0;
  end
  pready_zero_wait_a: assert property (pready == (psel && penable))
    else $error("pready not equal to access phase");
  err_data_zero_a: assert property (pslverr |-> psel && penable && prdata == 32'h0)
    else $error("error response outside access or with data");
  por_holds_core_a: assert property (supply_por_low |-> !core_reset_n)
    else $error("core out of reset with low supply");
  timer_holds_core_a: assert property (powerup_delay_running |-> !core_reset_n)
    else $error("core out of reset while delay timer runs");
  timer_length_a: assert property (run_cnt_r <= POWERUP_DELAY_TIMER_CYCLES)
    else $error("delay timer runs too long");
  timer_after_release_a: assert property (powerup_delay_running |-> !supply_por_low)
    else $error("delay timer runs during power-on condition");
  source_reset_a: assert property ((watchdog_timer_reset || reset_instruction || prog_mode_exit)
    |-> !core_reset_n)
    else $error("reset source did not hold core");
  uv_filter_a: assert property ($rose(brownout_generic) |-> uv_cnt_r >= FILT_CYC || lp_hist_r != 8'h00)
    else $error("brown-out raised before filter time");
  generic_resets_a: assert property (brownout_generic |-> ##[0:3] !core_reset_n)
    else $error("generic brown-out did not reset core");
  release_synced_a: assert property ($rose(core_reset_n) |-> $past(supply_por_low, 2) == 1'b0
    && $past(prog_mode_exit) == 1'b0)
    else $error("core released without synchronised quiet");
  timer_cov: cover property ($rose(powerup_delay_running));
  generic_cov: cover property ($rose(brownout_generic));
  release_cov: cover property ($rose(core_reset_n));
  err_cov: cover property (pslverr);
endmodule

bind bors_sequencer bors_props #(.POWERUP_DELAY_TIMER_CYCLES(POWERUP_DELAY_TIMER_CYCLES)) i_props (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .supply_por_low(supply_por_low), .undervoltage(undervoltage),
  .lowpower_supply_low(lowpower_supply_low), .watchdog_timer_reset(watchdog_timer_reset),
  .reset_instruction(reset_instruction), .prog_mode_exit(prog_mode_exit),
  .core_reset_n(core_reset_n), .brownout_generic(brownout_generic),
  .powerup_delay_running(powerup_delay_running));

/* tb/bors_analog_model.sv */
`timescale 1ns/1ps
module bors_analog_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // scenario control
  input wire logic por_req,
  input wire logic uv_req,
  input wire logic lp_req,
  input wire logic ready_block,
  // detector side
  input wire logic brownout_enable,
  output logic supply_por_low,
  output logic undervoltage,
  output logic brownout_circuit_ready,
  output logic lowpower_supply_low,
  output logic osc_startup_done
);
  logic [2:0] rdy_cnt_r;
  logic [3:0] osc_cnt_r;
  assign supply_por_low = por_req;
  assign undervoltage = uv_req;
  assign lowpower_supply_low = lp_req;
  assign brownout_circuit_ready = rdy_cnt_r == 3'h7;
  assign osc_startup_done = osc_cnt_r == 4'hF;
  // circuit settles some cycles after enable and drops at once when off
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) rdy_cnt_r <= 3'h0;
    else if (!brownout_enable || ready_block) rdy_cnt_r <= 3'h0;
    else if (rdy_cnt_r != 3'h7) rdy_cnt_r <= rdy_cnt_r + 3'h1;
  end
  // oscillator restarts on every power-on event
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) osc_cnt_r <= 4'h0;
    else if (por_req) osc_cnt_r <= 4'h0;
    else if (osc_cnt_r != 4'hF) osc_cnt_r <= osc_cnt_r + 4'h1;
  end
endmodule

/* tb/tb_top.sv */
`timescale 1ns/1ps
`include "bors_map.svh"
module tb_top;
  import bors_pkg::*;
  localparam int unsigned POWERUP_DELAY_TIMER_SIM = 50;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  bors_addr_t paddr = 8'h00;
  bors_data_t pwdata = 32'h0, prdata, rd_d;
  logic pready, pslverr, rd_e;
  logic supply_por_low, undervoltage, brownout_circuit_ready, lowpower_supply_low;
  logic osc_startup_done, core_reset_n, wake_stall, brownout_enable, bandgap_force_on;
  logic brownout_level_sel, brownout_generic, powerup_delay_running;
  // supply events for the analog model: 0 power-on, 1 undervoltage, 2 low-power monitor
  logic [2:0] dip_r = 3'h0;
  logic ready_block = 1'b0;
  logic core_sleep = 1'b0;
  logic [5:0] src_r = 6'h00;
  logic [3:0] mode_up = 4'b0011;
  int bad_count = 0;
  int check_count = 0;
  int n, cnt;
  always #2.5 pclk = ~pclk;
  bors_sequencer #(.POWERUP_DELAY_TIMER_CYCLES(POWERUP_DELAY_TIMER_SIM)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .supply_por_low(supply_por_low),
    .undervoltage(undervoltage), .brownout_circuit_ready(brownout_circuit_ready),
    .lowpower_supply_low(lowpower_supply_low), .external_reset_pin_n(~src_r[0]),
    .watchdog_timer_reset(src_r[1]), .reset_instruction(src_r[2]), .stack_overflow(src_r[3]),
    .stack_underflow(src_r[4]), .prog_mode_exit(src_r[5]), .osc_startup_done(osc_startup_done),
    .core_sleep(core_sleep), .core_reset_n(core_reset_n), .wake_stall(wake_stall),
    .brownout_enable(brownout_enable), .bandgap_force_on(bandgap_force_on),
    .brownout_level_sel(brownout_level_sel), .brownout_generic(brownout_generic),
    .powerup_delay_running(powerup_delay_running));
  bors_analog_model i_model (.pclk(pclk), .presetn(presetn), .por_req(dip_r[0]),
    .uv_req(dip_r[1]), .lp_req(dip_r[2]), .ready_block(ready_block),
    .brownout_enable(brownout_enable), .supply_por_low(supply_por_low),
    .undervoltage(undervoltage), .brownout_circuit_ready(brownout_circuit_ready),
    .lowpower_supply_low(lowpower_supply_low), .osc_startup_done(osc_startup_done));
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic check(input string what, input bors_data_t exp, input bors_data_t got);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic xfer(input logic wr, input bors_addr_t a, input bors_data_t wd);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd_d = prdata;
    rd_e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic rd_chk(input string what, input bors_addr_t a, input bors_data_t m,
    input bors_data_t exp);
    xfer(1'b0, a, 32'h0);
    check(what, exp, rd_d & m);
  endtask
  task automatic wait_up(input int lim);
    n = 0;
    @(negedge pclk);
    while (core_reset_n !== 1'b1 && n < lim) begin
      @(negedge pclk);
      n++;
    end
    check("core release", 32'h1, {31'h0, core_reset_n});
  endtask
  task automatic hold_in(input int idx, input int cyc);
    @(posedge pclk);
    dip_r[idx] <= 1'b1;
    repeat (cyc) @(posedge pclk);
    @(negedge pclk);
  endtask
  task automatic lift(input int idx);
    @(posedge pclk);
    dip_r[idx] <= 1'b0;
  endtask
  task automatic nap(input logic en, input logic stall);
    @(posedge pclk);
    core_sleep <= 1'b1;
    repeat (20) @(negedge pclk);
    check("sleep enable", {31'h0, en}, {31'h0, brownout_enable});
    @(posedge pclk);
    core_sleep <= 1'b0;
    repeat (2) @(negedge pclk);
    check("wake stall", {31'h0, stall}, {31'h0, wake_stall});
  endtask
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    wait_up(100);
    rd_chk("ctrl reset", `BORS_OFF_CTRL, 32'hFE, 32'h80);
    rd_chk("ctrl ready", `BORS_OFF_CTRL, 32'h01, 32'h01);
    rd_chk("cfg reset", `BORS_OFF_CFG, 32'hFF, 32'h67);
    xfer(1'b0, 8'h0C, 32'h0);
    check("unmapped err", 32'h1, {31'h0, rd_e});
    check("unmapped data", 32'h0, rd_d);
    xfer(1'b1, `BORS_OFF_CTRL, 32'hFF);
    rd_chk("ctrl set", `BORS_OFF_CTRL, 32'hFE, 32'hC0);
    xfer(1'b1, `BORS_OFF_CTRL, 32'h00);
    rd_chk("ctrl clear", `BORS_OFF_CTRL, 32'hFE, 32'h00);
    $display("test registers done");
    for (int i = 0; i < 6; i++) begin
      @(posedge pclk);
      src_r[i] <= 1'b1;
      repeat (3) @(posedge pclk);
      check("source reset", 32'h0, {31'h0, core_reset_n});
      src_r[i] <= 1'b0;
      wait_up(100);
    end
    $display("test sources done");
    xfer(1'b1, `BORS_OFF_CFG, 32'h63);
    hold_in(0, 5);
    check("timer during por", 32'h0, {31'h0, powerup_delay_running});
    lift(0);
    cnt = 0;
    for (int k = 0; k < 300 && core_reset_n !== 1'b1; k++) begin
      @(negedge pclk);
      if (powerup_delay_running === 1'b1) cnt++;
    end
    check("timer length", POWERUP_DELAY_TIMER_SIM, cnt);
    wait_up(10);
    $display("test timer done");
    xfer(1'b1, `BORS_OFF_CTRL, 32'h40);
    hold_in(1, 100);
    check("short dip", 32'h0, {31'h0, brownout_generic});
    lift(1);
    hold_in(1, 250);
    check("long dip", 32'h1, {31'h0, brownout_generic});
    lift(1);
    wait_up(300);
    rd_chk("ctrl restored", `BORS_OFF_CTRL, 32'hFE, 32'h80);
    rd_chk("bor flag", `BORS_OFF_STAT, 32'h01, 32'h01);
    xfer(1'b1, `BORS_OFF_STAT, 32'h01);
    $display("test brownout done");
    hold_in(2, 20);
    check("lp disabled", 32'h0, {31'h0, brownout_generic});
    lift(2);
    xfer(1'b1, `BORS_OFF_CFG, 32'h6B);
    hold_in(2, 20);
    check("lp generic", 32'h1, {31'h0, brownout_generic});
    check("lp core", 32'h0, {31'h0, core_reset_n});
    lift(2);
    wait_up(300);
    rd_chk("lp flag", `BORS_OFF_STAT, 32'h01, 32'h01);
    $display("test lowpower done");
    @(posedge pclk);
    ready_block <= 1'b1;
    for (int m = 0; m < 4; m++) begin
      xfer(1'b1, `BORS_OFF_CFG, 32'h64 | m);
      hold_in(0, 5);
      lift(0);
      repeat (100) @(posedge pclk);
      @(negedge pclk);
      check("mode start", {31'h0, mode_up[m]}, {31'h0, core_reset_n});
    end
    @(posedge pclk);
    ready_block <= 1'b0;
    wait_up(100);
    $display("test modes done");
    nap(1'b1, 1'b0);
    xfer(1'b1, `BORS_OFF_CFG, 32'h76);
    xfer(1'b1, `BORS_OFF_CTRL, 32'h40);
    repeat (2) @(negedge pclk);
    check("fast start", 32'h1, {31'h0, bandgap_force_on});
    check("level sel", 32'h1, {31'h0, brownout_level_sel});
    nap(1'b0, 1'b1);
    repeat (30) @(negedge pclk);
    check("wake done", 32'h0, {31'h0, wake_stall});
    check("awake", 32'h1, {31'h0, core_reset_n});
    $display("test sleep done");
    close_out();
  end
  initial begin
    #100000;
    bad_count++;
    close_out();
  end
endmodule
